//--- hdl/dmc_defines.vh
// Purpose: Constants for the mode, interface and SRAM register group
// Assumes: 8-bit register addresses, 16-bit register words
// Notes: Definitions only
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH
// Register addresses
`define DMC_ADDR_MODE 8'h25
`define DMC_ADDR_IFACE 8'h26
`define DMC_ADDR_SPTR 8'h2b
`define DMC_ADDR_SDATA 8'h2c
// Alternate command codes on the configuration page
`define DMC_PAGE_CFG 8'hff
`define DMC_CMD_MODE 8'he9
`define DMC_CMD_SPTR 8'hef
`define DMC_CMD_SDATA 8'hf0
// Reset value of the mode, interface and read data registers
`define DMC_RST 16'h0000
// Mode register fields
`define DMC_LOWPWR_BIT 13
`define DMC_PROT_HI 9
`define DMC_PROT_LO 8
`define DMC_PROT_HIZ 2'b00
`define DMC_PROT_NVM 2'b01
`define DMC_PROT_MLOW 2'b10
`define DMC_PROT_MHIGH 2'b11
// Writable bits of the mode register (don't-care 4-0 kept as R/W)
`define DMC_MODE_MASK 16'hffff
// Interface register fields
`define DMC_TIMEOUT_BIT 12
`define DMC_PMBUS_BIT 8
`define DMC_FSDO_BIT 2
`define DMC_SDO_BIT 0
`define DMC_IFACE_MASK 16'h1105
// Pointer field
`define DMC_PTR_MASK 16'h00ff
`define DMC_PTR_HI 7
`define DMC_PTR_LO 0
// Pointer reset value
`define DMC_PTR_RST 8'h00
`endif

//--- hdl/dmc_regs.v
// Purpose: Mode, interface and indirect SRAM register group with protect sequencer
// Assumes: Host access decoded upstream into strobes; slew engine outside
// Notes: Outputs registered; protect pin synchronised internally
//
// How it works
// RQ1: Response 00: immediate Hi-Z power-down, no slew
// RQ2: Response 01: load stored code, then Hi-Z
// RQ3: Response 10: slew to margin-low, then Hi-Z
// RQ4: Response 11: slew to margin-high, then Hi-Z
// RQ5: Host sets bit 13 for low power
// RQ6: Bit 12 enables I2C timeout
// RQ7: Bit 8 enables PMBus, reset off
// RQ8: Bit 2 selects fast serial out
// RQ9: Bit 0 routes serial out to pin
// RQ10: Pointer write sets next SRAM location
// RQ11: Pointer advances after each data write
// RQ12: Data port writes/reads word at pointer
// RQ13: PMBus page FFh E9h reaches mode register
// RQ14: PMBus FFh: EFh pointer, F0h data
// RQ15: Falling protect edge starts response; high ignored
// RQ16: Host writes zeros to reserved bits
`timescale 1ns/1ps
`include "dmc_defines.vh"
`default_nettype none

module dmc_regs #(
  parameter DEPTH = 256
) (
  input wire clk,
  input wire nrst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire [7:0] pmbus_page,
  input wire protect_pin_n,
  input wire protect_pin_sel,
  input wire slew_done,
  output reg [15:0] rdata,
  output reg rvalid,
  output reg low_power_select,
  output reg timeout_en,
  output reg pmbus_en,
  output reg fast_serial_out_on,
  output reg serial_out_on_pin,
  output reg hiz_pdn,
  output reg load_nvm_code,
  output reg slew_to_low,
  output reg slew_to_high
);

  // ---------------------------------------------
  // Address decode
  // ---------------------------------------------
  localparam SEL_NONE = 3'd0;
  localparam SEL_MODE = 3'd1;
  localparam SEL_IFACE = 3'd2;
  localparam SEL_SPTR = 3'd3;
  localparam SEL_SDATA = 3'd4;

  // Map an access to a register; PMBus uses command codes on page FFh
  function [2:0] dec;
    input [7:0] a;
    input pm;
    input [7:0] pg;
    begin
      dec = SEL_NONE;
      if (pm) begin
        if (pg == `DMC_PAGE_CFG) begin
          if (a == `DMC_CMD_MODE) dec = SEL_MODE; // RQ13
          else if (a == `DMC_CMD_SPTR) dec = SEL_SPTR; // RQ14
          else if (a == `DMC_CMD_SDATA) dec = SEL_SDATA; // RQ14
        end
      end else begin
        if (a == `DMC_ADDR_MODE) dec = SEL_MODE;
        else if (a == `DMC_ADDR_IFACE) dec = SEL_IFACE;
        else if (a == `DMC_ADDR_SPTR) dec = SEL_SPTR;
        else if (a == `DMC_ADDR_SDATA) dec = SEL_SDATA;
      end
    end
  endfunction

  wire [2:0] sel = dec(addr, pmbus_en, pmbus_page); // Shared for reads and writes

  // ---------------------------------------------
  // Register storage
  // ---------------------------------------------
  reg [15:0] mode_reg; // Whole word stored; reserved bits kept as written
  reg [15:0] iface_reg; // Only defined bits kept
  reg [7:0] sram_ptr; // Next SRAM location
  reg [15:0] sram_mem [0:DEPTH-1]; // Indirect SRAM

  // Control registers; reserved values rely on the host writing zeros (RQ16)
  always @(posedge clk) begin
    if (!nrst) begin
      mode_reg <= `DMC_RST;
      iface_reg <= `DMC_RST;
      sram_ptr <= `DMC_PTR_RST;
    end else if (wr_en) begin
      case (sel)
        SEL_MODE: mode_reg <= wdata & `DMC_MODE_MASK;
        SEL_IFACE: iface_reg <= wdata & `DMC_IFACE_MASK; // RQ7
        SEL_SPTR: sram_ptr <= wdata[`DMC_PTR_HI:`DMC_PTR_LO]; // RQ10
        SEL_SDATA: sram_ptr <= sram_ptr + 8'h01; // RQ11
        default: sram_ptr <= sram_ptr;
      endcase
    end
  end

  // SRAM array has no reset; contents undefined until written
  always @(posedge clk) begin
    if (wr_en && sel == SEL_SDATA) begin
      sram_mem[sram_ptr] <= wdata; // RQ12
    end
  end

  // ---------------------------------------------
  // Read path
  // ---------------------------------------------
  // One-cycle read latency; unmapped reads return zero
  always @(posedge clk) begin
    if (!nrst) begin
      rdata <= `DMC_RST;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      if (rd_en) begin
        case (sel)
          SEL_MODE: rdata <= mode_reg;
          SEL_IFACE: rdata <= iface_reg;
          SEL_SPTR: rdata <= {8'h00, sram_ptr};
          SEL_SDATA: rdata <= sram_mem[sram_ptr]; // RQ12
          default: rdata <= `DMC_RST;
        endcase
      end
    end
  end

  // ---------------------------------------------
  // Configuration outputs
  // ---------------------------------------------
  // Registered copies so outputs come straight from flops
  always @(posedge clk) begin
    if (!nrst) begin
      low_power_select <= 1'b0;
      timeout_en <= 1'b0;
      pmbus_en <= 1'b0;
      fast_serial_out_on <= 1'b0;
      serial_out_on_pin <= 1'b0;
    end else begin
      low_power_select <= mode_reg[`DMC_LOWPWR_BIT]; // RQ5
      timeout_en <= iface_reg[`DMC_TIMEOUT_BIT]; // RQ6
      pmbus_en <= iface_reg[`DMC_PMBUS_BIT]; // RQ7
      fast_serial_out_on <= iface_reg[`DMC_FSDO_BIT]; // RQ8
      serial_out_on_pin <= iface_reg[`DMC_SDO_BIT]; // RQ9
    end
  end

  // ---------------------------------------------
  // Protect pin synchroniser and edge detect
  // ---------------------------------------------
  reg prot_s1; // First stage, read only by second stage
  reg prot_s2;
  reg prot_s3; // Previous level for edge detect
  always @(posedge clk) begin
    if (!nrst) begin
      prot_s1 <= 1'b1;
      prot_s2 <= 1'b1;
      prot_s3 <= 1'b1;
    end else begin
      prot_s1 <= protect_pin_n;
      prot_s2 <= prot_s1;
      prot_s3 <= prot_s2;
    end
  end
  // Only a falling edge counts; a steady high does nothing
  wire prot_fall = protect_pin_sel & prot_s3 & ~prot_s2; // RQ15

  // ---------------------------------------------
  // Protect sequencer
  // ---------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_LOAD = 2'd1;
  localparam ST_SLEW = 2'd2;
  localparam ST_HIZ = 2'd3;
  reg [1:0] state;
  wire [1:0] resp = mode_reg[`DMC_PROT_HI:`DMC_PROT_LO];

  // Hi-Z is terminal until reset; a new edge while busy is ignored
  always @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      hiz_pdn <= 1'b0;
      load_nvm_code <= 1'b0;
      slew_to_low <= 1'b0;
      slew_to_high <= 1'b0;
    end else begin
      load_nvm_code <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (prot_fall) begin
            case (resp)
              `DMC_PROT_HIZ: begin
                state <= ST_HIZ;
                hiz_pdn <= 1'b1; // RQ1
              end
              `DMC_PROT_NVM: begin
                state <= ST_LOAD;
                load_nvm_code <= 1'b1; // RQ2
              end
              `DMC_PROT_MLOW: begin
                state <= ST_SLEW;
                slew_to_low <= 1'b1; // RQ3
              end
              default: begin
                state <= ST_SLEW;
                slew_to_high <= 1'b1; // RQ4
              end
            endcase
          end
        end
        ST_LOAD: begin
          state <= ST_HIZ;
          hiz_pdn <= 1'b1; // RQ2
        end
        ST_SLEW: begin
          if (slew_done) begin
            state <= ST_HIZ;
            slew_to_low <= 1'b0;
            slew_to_high <= 1'b0;
            hiz_pdn <= 1'b1; // RQ3 RQ4
          end
        end
        default: state <= ST_HIZ;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- testbench/dmc_regs_assertions.sv
// Purpose: Port checks for the mode, interface and SRAM registers
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto every register group instance
`timescale 1ns/1ps
`default_nettype none
module dmc_regs_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rvalid,
  input wire logic low_power_select,
  input wire logic timeout_en,
  input wire logic pmbus_en,
  input wire logic fast_serial_out_on,
  input wire logic serial_out_on_pin,
  input wire logic hiz_pdn,
  input wire logic load_nvm_code,
  input wire logic slew_to_low,
  input wire logic slew_to_high,
  input wire logic slew_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Plain-address write lands on its output two edges later
  property cfg_p(a, b, o);
    wr_en && addr == a && !pmbus_en |-> ##2 o == $past(wdata[b], 2);
  endproperty
  // Stored code pulse, then power-down
  sequence nvm_s; load_nvm_code ##1 (hiz_pdn && !load_nvm_code); endsequence
  // Slew target reached
  sequence arrive_s; (slew_to_low || slew_to_high) && slew_done; endsequence
  a_low_power: assert property (cfg_p(8'h25, 13, low_power_select)) else $error("low power bit");
  a_timeout_bit: assert property (cfg_p(8'h26, 12, timeout_en)) else $error("timeout bit");
  a_pmbus_bit: assert property (cfg_p(8'h26, 8, pmbus_en)) else $error("pmbus bit");
  a_fast_out: assert property (cfg_p(8'h26, 2, fast_serial_out_on)) else $error("fast out bit");
  a_read_answer: assert property (rd_en |=> rvalid) else $error("no read answer");
  a_nvm_then_hiz: assert property (load_nvm_code |-> nvm_s) else $error("no power-down after load");
  a_slew_finish: assert property (arrive_s |=> hiz_pdn && !slew_to_low && !slew_to_high) else $error("slew end");
  a_hiz_sticky: assert property (hiz_pdn |=> hiz_pdn) else $error("power-down dropped");
  // Power-down never overlaps a load pulse or a slew request
  a_hiz_alone: assert property (hiz_pdn |-> !load_nvm_code && !slew_to_low && !slew_to_high) else $error("hiz overlap");
  a_serial_pin: assert property (cfg_p(8'h26, 0, serial_out_on_pin)) else $error("serial pin bit");
endmodule
bind dmc_regs dmc_regs_assertions dmc_regs_assertions_inst (.clk, .nrst, .wr_en, .rd_en, .addr, .wdata, .rvalid,
  .low_power_select, .timeout_en, .pmbus_en, .fast_serial_out_on, .serial_out_on_pin, .hiz_pdn, .load_nvm_code,
  .slew_to_low, .slew_to_high, .slew_done);
`default_nettype wire

//--- testbench/dmc_slew_model.sv
// Purpose: Slew engine stand-in
// Assumes: Slewing request is a level
// Notes: Arrival delay set by the bench, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module dmc_slew_model (
  input wire logic clk,
  input wire logic slewing,
  input wire logic [3:0] dly,
  output logic slew_done = 1'b0
);
  logic [3:0] cnt = 4'h0; // Cycles spent slewing
  // Target reached after dly cycles; drops once slewing stops
  always @(posedge clk) begin
    cnt <= slewing ? cnt + 4'h1 : 4'h0;
    slew_done <= slewing && cnt >= dly;
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the mode, interface and SRAM registers
// Assumes: Reads noted in a queue, checked by a watcher
// Notes: Protect run once per reset, all four responses
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, protect_pin_n = 1'b1, protect_pin_sel = 1'b0;
  logic [7:0] addr = 8'h00, pmbus_page = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, m, p;
  logic rvalid, low_power_select, timeout_en, pmbus_en, fast_serial_out_on, serial_out_on_pin;
  logic hiz_pdn, load_nvm_code, slew_to_low, slew_to_high, slew_done;
  logic [3:0] dly = 4'h0;
  logic [7:0] ra[4] = '{8'h25, 8'h26, 8'h2b, 8'h30}; // Last one unmapped
  logic [15:0] exp_q[$];
  int mismatches = 0, checked = 0, n;
  dmc_regs dmc_regs_inst (.clk, .nrst, .wr_en, .rd_en, .addr, .wdata, .pmbus_page, .protect_pin_n, .protect_pin_sel,
    .slew_done, .rdata, .rvalid, .low_power_select, .timeout_en, .pmbus_en, .fast_serial_out_on, .serial_out_on_pin,
    .hiz_pdn, .load_nvm_code, .slew_to_low, .slew_to_high);
  dmc_slew_model dmc_slew_model_inst (.clk, .slewing(slew_to_low | slew_to_high), .dly, .slew_done);
  initial forever #5 clk = ~clk;
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One access; on a read, d is the expected word
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
    if (!w) exp_q.push_back(d);
    @(posedge clk) #1;
    {wr_en, rd_en} = 2'b00;
  endtask
  // Watcher: each read answer against the oldest note
  always @(posedge clk) if (rvalid === 1'b1) check("rdata", rdata, exp_q.pop_front());
  initial begin
    void'($urandom(32'hc2cc9142));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    foreach (ra[i]) bus(0, ra[i], 16'h0000);
    m = $urandom() & 16'hfeff;
    bus(1, 8'h26, m);
    bus(0, 8'h26, m & 16'h1105);
    check("iface", {timeout_en, fast_serial_out_on, serial_out_on_pin, pmbus_en}, {m[12], m[2], m[0], 1'b0});
    m = $urandom() & 16'h231f;
    bus(1, 8'h25, m);
    bus(0, 8'h25, m);
    check("low_power", low_power_select, m[13]);
    // Indirect SRAM: two writes back to back, pointer walks
    p = $urandom_range(250);
    m = $urandom();
    bus(1, 8'h2b, p);
    bus(1, 8'h2c, m);
    bus(1, 8'h2c, ~m);
    bus(0, 8'h2b, p + 16'h2);
    bus(1, 8'h2b, p + 16'h1);
    bus(0, 8'h2c, ~m);
    bus(0, 8'h2b, p + 16'h1);
    // PMBus mode: plain addresses and other pages refused
    bus(1, 8'h26, 16'h0100);
    pmbus_page = 8'hff;
    bus(1, 8'he9, 16'h2000);
    bus(0, 8'he9, 16'h2000);
    bus(1, 8'hef, p);
    bus(0, 8'hf0, m);
    bus(0, 8'hef, p);
    bus(0, 8'h25, 16'h0000);
    pmbus_page = 8'h03;
    bus(0, 8'he9, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      {nrst, pmbus_page, protect_pin_sel, protect_pin_n} = {1'b0, 8'h00, 2'b01};
      dly = 4'($urandom_range(9));
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      bus(1, 8'h25, 16'(k << 8));
      // Pin pulse while not selected as protect input must be ignored
      protect_pin_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 protect_pin_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 check("idle", {hiz_pdn, load_nvm_code, slew_to_low, slew_to_high}, 16'h0);
      protect_pin_sel = 1'b1;
      protect_pin_n = 1'b0;
      for (n = 0; !(hiz_pdn | load_nvm_code | slew_to_low | slew_to_high) && n < 30; n++) @(posedge clk) #1;
      check("start", {hiz_pdn, load_nvm_code, slew_to_low, slew_to_high, n < 6}, {4'h8 >> k, 1'b1});
      if (n > 29) end_sim;
      for (n = 0; !hiz_pdn && n < 30; n++) @(posedge clk) #1;
      check("finish", {hiz_pdn, slew_to_low, slew_to_high, n < 30}, 16'h9);
      if (n > 29) end_sim;
    end
    end_sim;
  end
endmodule
`default_nettype wire
